// file: hdl/pamc_map.svh
`ifndef PAMC_MAP_SVH
`define PAMC_MAP_SVH

// Register byte offsets
`define PAMC_OFS_RSVD    8'h44
`define PAMC_OFS_ARB     8'h48
`define PAMC_OFS_STAT    8'h80

// Field positions in the arbiter word
`define PAMC_EN_MSB      4
`define PAMC_BIT_EXT     9
`define PAMC_BIT_BMTO    10
`define PAMC_BIT_REFRESH 11

// Reset values
`define PAMC_RST_EN      5'h1f
`define PAMC_RST_EXT     1'b0
`define PAMC_RST_BMTO    1'b0
`define PAMC_RST_REFRESH 1'b0

// Requesters and timing
`define PAMC_NREQ        5
`define PAMC_NPIN        7
`define PAMC_BM_CYCLES   5'h10

`endif

// file: hdl/pamc_pkg.sv
`default_nettype none

package pamc_pkg;

   // Software controls of the arbiter word
   typedef struct packed {
      logic       refresh;
      logic       bm_en;
      logic       ext_arb;
      logic [4:0] en;
   } pamc_ctrl_t;

   // Grant sequencing
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_GRANT = 3'b010,
      ST_BUSY  = 3'b100
   } pamc_state_t;

endpackage : pamc_pkg

`default_nettype wire

// file: hdl/pamc_bm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "pamc_map.svh"

module pamc_bm_timer (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       run_i,
   input  wire logic       clr_i,
   // Status
   output var  logic [4:0] cnt_o,
   output var  logic       exp_o
);

   logic [4:0] cnt_q;
   logic [4:0] cnt_d;

   // Counts idle waiting cycles, stops at expiry
   assign cnt_d = clr_i ? 5'h00 :
                  (run_i && !exp_o) ? 5'(cnt_q + 5'h01) : cnt_q;
   assign cnt_o = cnt_q;
   assign exp_o = (cnt_q == `PAMC_BM_CYCLES);

   // Counter register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 5'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Expiry holds until cleared
   a_expiry_holds: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exp_o && !clr_i |=> exp_o)
      else $error("expiry flag dropped without clear");

endmodule // pamc_bm_timer

`default_nettype wire

// file: hdl/pamc_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
`include "pamc_map.svh"

////////////////////////////////////////////////////////////////////////////
module pamc_arbiter (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // Bridge internal requester
   input  wire logic        int_req_i,
   output var  logic        int_gnt_o,
   // Secondary bus pins
   input  wire logic [4:1]  req_n_i,
   output var  logic [4:1]  gnt_n_o,
   input  wire logic        frame_n_i,
   input  wire logic        irdy_n_i,
   // External arbiter pins
   output var  logic        ext_req_n_o,
   input  wire logic        ext_gnt_n_i
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [`PAMC_NPIN-1:0] pin_raw;
   logic [`PAMC_NPIN-1:0] pin_q;

   assign pin_raw = {ext_gnt_n_i, irdy_n_i, frame_n_i, req_n_i};

   // Three stages, a change counts once stages two and three agree
   for (genvar g = 0; g < `PAMC_NPIN; g++) begin : g_sync
      logic [2:0] sh_q;
      logic       filt_q;
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            sh_q   <= 3'h7;
            filt_q <= 1'b1;
         end else begin
            sh_q <= {sh_q[1:0], pin_raw[g]};
            if (sh_q[1] == sh_q[2]) begin
               filt_q <= sh_q[2];
            end
         end
      end
      assign pin_q[g] = filt_q;
   end

   logic                  frame_seen;
   logic                  bus_idle;
   logic                  ext_gnt;
   logic [`PAMC_NREQ-1:0] req_vec;

   // Decoded bus conditions
   assign frame_seen = !pin_q[4];
   assign bus_idle   = pin_q[4] && pin_q[5];
   assign ext_gnt    = !pin_q[6];
   assign req_vec    = {~pin_q[3:0], int_req_i};

   ////////////////////////////////////////////////////////////////////////
   // Register file

   pamc_pkg::pamc_ctrl_t  ctrl_q;
   logic [`PAMC_NREQ-1:0] broken_q;
   logic [`PAMC_NREQ-1:0] grant_q;
   logic [31:0]           arb_word;
   logic [31:0]           stat_word;
   logic [31:0]           rd_data;
   logic                  bus_req;
   logic                  hit_rsvd;
   logic                  hit_arb;
   logic                  hit_stat;
   logic                  wr_arb;

   // Address decode and read selection
   assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign hit_rsvd = (wb_adr_i == `PAMC_OFS_RSVD);
   assign hit_arb  = (wb_adr_i == `PAMC_OFS_ARB);
   assign hit_stat = (wb_adr_i == `PAMC_OFS_STAT);
   assign wr_arb   = bus_req && wb_we_i && hit_arb;
   assign arb_word = {20'h0_0000, ctrl_q.refresh, ctrl_q.bm_en,
                      ctrl_q.ext_arb, 4'h0, ctrl_q.en};
   assign stat_word = {19'h0_0000, grant_q, 3'h0, broken_q};
   assign rd_data  = hit_arb  ? arb_word  :
                     hit_stat ? stat_word : 32'h0000_0000;

   // Control bits, byte lanes 0 and 1
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q.en      <= `PAMC_RST_EN;
         ctrl_q.ext_arb <= `PAMC_RST_EXT;
         ctrl_q.bm_en   <= `PAMC_RST_BMTO;
         ctrl_q.refresh <= `PAMC_RST_REFRESH;
      end else if (wr_arb) begin
         if (wb_sel_i[0]) begin
            ctrl_q.en <= wb_dat_i[`PAMC_EN_MSB:0];
         end
         if (wb_sel_i[1]) begin
            ctrl_q.ext_arb <= wb_dat_i[`PAMC_BIT_EXT];
            ctrl_q.bm_en   <= wb_dat_i[`PAMC_BIT_BMTO];
            ctrl_q.refresh <= wb_dat_i[`PAMC_BIT_REFRESH];
         end
      end
   end

   // One-cycle answer, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbitration

   pamc_pkg::pamc_state_t state_q;
   pamc_pkg::pamc_state_t state_d;
   logic [`PAMC_NREQ-1:0] eligible;
   logic [`PAMC_NREQ-1:0] grant_d;
   logic [`PAMC_NREQ-1:0] served_q;
   logic [2:0]            last_q;
   logic [2:0]            pick;
   logic                  arb_on;
   logic                  own_req;
   logic                  all_served;
   logic                  tmo_run;
   logic                  tmo_clr;
   logic                  tmo_exp;
   logic                  tmo_hit;
   logic [4:0]            tmo_cnt;

   // Enabled, not broken, requesting
   assign arb_on   = !ctrl_q.ext_arb;
   assign eligible = req_vec & ctrl_q.en & ~broken_q;
   assign own_req  = |(grant_q & req_vec & ctrl_q.en);
   assign all_served = (|served_q) &&
                       (&(served_q | broken_q | ~(req_vec & ctrl_q.en)));

   // Round robin search starting after the last owner
   always_comb begin
      logic [2:0] idx;
      idx  = last_q;
      pick = last_q;
      for (int k = `PAMC_NREQ; k >= 1; k--) begin
         idx = 3'((32'(last_q) + k) % `PAMC_NREQ);
         if (eligible[idx]) begin
            pick = idx;
         end
      end
   end

   // Broken-master timer controls
   assign tmo_run = (state_q == pamc_pkg::ST_GRANT) && ctrl_q.bm_en &&
                    bus_idle && !frame_seen;
   assign tmo_clr = frame_seen || (state_q != pamc_pkg::ST_GRANT) ||
                    !ctrl_q.bm_en;
   assign tmo_hit = tmo_exp && ctrl_q.bm_en && !frame_seen &&
                    (state_q == pamc_pkg::ST_GRANT);

   pamc_bm_timer u_bm_timer (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .run_i (tmo_run),
      .clr_i (tmo_clr),
      .cnt_o (tmo_cnt),
      .exp_o (tmo_exp)
   );

   // Grant sequencing
   always_comb begin
      state_d = state_q;
      grant_d = grant_q;
      unique case (state_q)
         pamc_pkg::ST_IDLE: begin
            grant_d = '0;
            if (arb_on && bus_idle && (|eligible)) begin
               grant_d = `PAMC_NREQ'(1) << pick;
               state_d = pamc_pkg::ST_GRANT;
            end
         end
         pamc_pkg::ST_GRANT: begin
            if (!arb_on || tmo_hit || (!own_req && !frame_seen)) begin
               grant_d = '0;
               state_d = pamc_pkg::ST_IDLE;
            end else if (frame_seen) begin
               state_d = pamc_pkg::ST_BUSY;
            end
         end
         pamc_pkg::ST_BUSY: begin
            if (!arb_on || (!own_req && bus_idle)) begin
               grant_d = '0;
               state_d = pamc_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // Arbiter state and grant pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q     <= pamc_pkg::ST_IDLE;
         grant_q     <= '0;
         last_q      <= 3'h0;
         gnt_n_o     <= 4'hf;
         int_gnt_o   <= 1'b0;
         ext_req_n_o <= 1'b1;
      end else begin
         state_q     <= state_d;
         grant_q     <= grant_d;
         gnt_n_o     <= ~grant_d[4:1];
         int_gnt_o   <= ctrl_q.ext_arb ? ext_gnt : grant_d[0];
         ext_req_n_o <= !(ctrl_q.ext_arb && int_req_i);
         if (state_q == pamc_pkg::ST_IDLE &&
             state_d == pamc_pkg::ST_GRANT) begin
            last_q <= pick;
         end
      end
   end

   // Broken marks; a timeout set wins over a refresh clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         broken_q <= '0;
         served_q <= '0;
      end else if (tmo_hit) begin
         broken_q <= broken_q | grant_q;
         served_q <= '0;
      end else if (state_q == pamc_pkg::ST_IDLE) begin
         if (ctrl_q.refresh && (|broken_q) && all_served) begin
            broken_q <= '0;
            served_q <= '0;
         end else if (state_d == pamc_pkg::ST_GRANT) begin
            served_q <= served_q | grant_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [7:0] wait_cnt;

   // Idle waiting cycles since the grant, for the timeout check
   always_ff @(posedge clk_i) begin
      if (rst_i || tmo_clr) begin
         wait_cnt <= 8'h00;
      end else if (tmo_run && wait_cnt != 8'hff) begin
         wait_cnt <= 8'(wait_cnt + 8'h01);
      end
   end

   sequence s_new_grant;
      state_q == pamc_pkg::ST_IDLE ##1 state_q == pamc_pkg::ST_GRANT;
   endsequence

   a_int_enable_gate: assert property (
      $rose(grant_q[0]) |-> $past(ctrl_q.en[0] && int_req_i))
      else $error("internal request granted while disabled");

   a_master_enable_gate: assert property (
      s_new_grant |-> (grant_q & ~$past(ctrl_q.en)) == '0)
      else $error("disabled master granted");

   a_ext_mode_quiet: assert property (
      ctrl_q.ext_arb |=> gnt_n_o == 4'hf ##0 state_q == pamc_pkg::ST_IDLE)
      else $error("internal grant while external arbiter selected");

   a_timeout_off: assert property (
      !ctrl_q.bm_en |=> tmo_cnt == 5'h00 && !tmo_exp)
      else $error("timeout counts while disabled");

   a_timeout_length: assert property (
      $rose(tmo_exp) |-> wait_cnt == 8'h10 && $past(tmo_run))
      else $error("timeout expired after wrong cycle count");

   a_timeout_drop: assert property (
      tmo_hit |=> grant_q == '0 && gnt_n_o == 4'hf && !int_gnt_o)
      else $error("grant kept after timeout");

   a_broken_kept: assert property (
      !ctrl_q.refresh |=> ($past(broken_q) & ~broken_q) == '0)
      else $error("broken master refreshed while refresh off");

   a_broken_skip: assert property (
      s_new_grant |-> (grant_q & $past(broken_q)) == '0)
      else $error("broken master granted");

   a_count_clear: assert property (
      frame_seen || !ctrl_q.bm_en |=> tmo_cnt == 5'h00)
      else $error("timeout count not cleared");

   a_bus_answer: assert property (
      bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not a single cycle");

endmodule // pamc_arbiter

`default_nettype wire

// file: tb/pamc_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// Four bus masters; a broken one requests but never starts a frame
module pamc_master_model (
   // Clock
   input  wire logic       clk_i,
   // Scenario controls
   input  wire logic [4:1] want_i,
   input  wire logic [4:1] broken_i,
   input  wire logic [3:0] delay_i,
   // Bus pins
   input  wire logic [4:1] gnt_n_i,
   output var  logic [4:1] req_n_o,
   output var  logic       frame_n_o,
   output var  logic       irdy_n_o
);
   logic [4:1] done_q = 4'h0;
   logic [3:0] wait_q = 4'h0;
   logic [2:0] xfer_q = 3'h0;
   wire  [4:1] mine   = ~gnt_n_i & want_i & ~broken_i & ~done_q;

   // Request held until the own transfer starts
   assign req_n_o   = ~(want_i & ~done_q);
   // Frame and irdy are driven high by the model outside its own transfer
   assign frame_n_o = ~(xfer_q >= 3'h3);
   assign irdy_n_o  = ~(xfer_q >= 3'h2);

   // Frame starts delay_i cycles after the grant is seen
   always @(posedge clk_i) begin
      done_q <= done_q & want_i;
      if (xfer_q != 3'h0) begin
         xfer_q <= xfer_q - 3'h1;
      end else if (|mine && wait_q == delay_i) begin
         xfer_q <= 3'h4;
         done_q <= (done_q & want_i) | mine;
         wait_q <= 4'h0;
      end else if (|mine) begin
         wait_q <= wait_q + 4'h1;
      end else begin
         wait_q <= 4'h0;
      end
   end
endmodule // pamc_master_model

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        int_req_i = 1'b0;
   logic        int_gnt_o;
   logic        ext_req_n_o;
   logic        ext_gnt_n_i = 1'b1;
   logic [4:1]  req_n, gnt_n_o, want = 4'h0, broken = 4'h0;
   logic [3:0]  delay = 4'h1;
   logic        frame_n, irdy_n;
   int          err_total = 0;
   int          check_count = 0;
   wire  [4:0]  gview = {~gnt_n_o, int_gnt_o};

   // Bus clock, 25 ns period
   always #12.5 clk_i = ~clk_i;

   pamc_arbiter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .int_req_i(int_req_i), .int_gnt_o(int_gnt_o),
      .req_n_i(req_n), .gnt_n_o(gnt_n_o), .frame_n_i(frame_n),
      .irdy_n_i(irdy_n), .ext_req_n_o(ext_req_n_o),
      .ext_gnt_n_i(ext_gnt_n_i));

   pamc_master_model model (.clk_i(clk_i), .want_i(want),
      .broken_i(broken), .delay_i(delay), .gnt_n_i(gnt_n_o),
      .req_n_o(req_n), .frame_n_o(frame_n), .irdy_n_o(irdy_n));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // Control image that reads back after a write
   function automatic logic [31:0] arb_img(input logic [15:0] v);
      return {16'h0000, v & 16'h0E1F};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Classic single Wishbone cycle, waits for ack under a bound
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n == 20) begin
         err_total++;
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, 4'hf, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0000_0000, 4'hf, r);
      check(r, e);
   endtask

   task automatic wait_grant(input logic [4:0] e);
      for (int n = 0; n < 40 && gview !== e; n++) @(posedge clk_i);
      check(32'(gview), 32'(e));
   endtask

   // Edges sampled with any grant still active
   task automatic hold_len(output int n);
      for (n = 0; n < 200 && gview !== 5'h00; n++) @(posedge clk_i);
      if (n == 200) begin
         err_total++;
      end
   endtask

   // Grants seen at any time over 40 cycles
   task automatic quiet(output logic [4:0] s);
      s = 5'h00;
      repeat (40) begin
         @(posedge clk_i);
         s |= gview;
      end
   endtask

   // Watchdog on the whole run
   initial begin
      repeat (100000) @(posedge clk_i);
      err_total++;
      complete_run();
   end

   // Main sequence
   initial begin
      logic [15:0] rnd;
      logic [31:0] r;
      logic [4:0]  s;
      int          n;
      rnd = 16'h68D6;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(8'h48, 32'h0000_001F);
      wr(8'h44, 32'hFFFF_FFFF);
      rd_chk(8'h44, 32'h0000_0000);
      rd_chk(8'h10, 32'h0000_0000);
      // Random images keep only the control bits
      repeat (6) begin
         rnd = lfsr(rnd);
         wr(8'h48, {16'h0000, rnd});
         rd_chk(8'h48, arb_img(rnd));
      end
      wb(1'b1, 8'h48, 32'hFFFF_FFFF, 4'hc, r);
      rd_chk(8'h48, arb_img(rnd));
      // Internal requester alone enabled, master 2 excluded
      wr(8'h48, 32'h0000_0001);
      int_req_i <= 1'b1;
      want <= 4'h2;
      wait_grant(5'h01);
      int_req_i <= 1'b0;
      hold_len(n);
      wr(8'h48, 32'h0000_0000);
      int_req_i <= 1'b1;
      quiet(s);
      check(32'(s), 32'h0000_0000);
      // External arbiter mode
      wr(8'h48, 32'h0000_021F);
      repeat (8) @(posedge clk_i);
      check(32'(ext_req_n_o), 32'h0000_0000);
      ext_gnt_n_i <= 1'b0;
      quiet(s);
      check(32'(s), 32'h0000_0001);
      ext_gnt_n_i <= 1'b1;
      int_req_i <= 1'b0;
      want <= 4'h0;
      wr(8'h48, 32'h0000_001F);
      repeat (8) @(posedge clk_i);
      check(32'(ext_req_n_o), 32'h0000_0001);
      // Master 3 never starts a frame
      wr(8'h48, 32'h0000_0408);
      broken <= 4'h4;
      want <= 4'h4;
      wait_grant(5'h08);
      hold_len(n);
      check(32'(n), 32'h0000_0011);
      rd_chk(8'h80, 32'h0000_0008);
      want <= 4'h0;
      repeat (3) @(posedge clk_i);
      want <= 4'h4;
      quiet(s);
      check(32'(s), 32'h0000_0000);
      want <= 4'h0;
      // Well behaved masters start late but inside the window
      for (int k = 1; k < 3; k++) begin
         rnd = lfsr(rnd);
         delay <= {1'b0, rnd[2:0]} + 4'h1;
         wr(8'h48, 32'h0000_0400 | (32'h1 << k));
         want <= 4'(1 << (k - 1));
         wait_grant(5'(1 << k));
         hold_len(n);
         rd_chk(8'h80, 32'h0000_0008);
         want <= 4'h0;
      end
      // Refresh on: masters 1 and 2 were served, so master 3 returns
      wr(8'h48, 32'h0000_0808);
      rd_chk(8'h80, 32'h0000_0000);
      want <= 4'h4;
      wait_grant(5'h08);
      want <= 4'h0;
      hold_len(n);
      // Timeout off: a silent master keeps its grant
      wr(8'h48, 32'h0000_0010);
      broken <= 4'hC;
      want <= 4'h8;
      wait_grant(5'h10);
      repeat (60) @(posedge clk_i);
      check(32'(gview), 32'h0000_0010);
      want <= 4'h0;
      // Reset in mid-run restores the defaults
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      check(32'(gview), 32'h0000_0000);
      check(32'(ext_req_n_o), 32'h0000_0001);
      rd_chk(8'h48, 32'h0000_001F);
      rd_chk(8'h80, 32'h0000_0000);
      complete_run();
   end
endmodule // tb_top

`default_nettype wire
